// *** wfp_map.svh ***
`ifndef WFP_MAP_SVH
`define WFP_MAP_SVH

// ****************************************************************
// Address layout
// ****************************************************************
`define WFP_ADDR_W          8
`define WFP_IDX_W           6
`define WFP_IDX_CRC_LOW     6'h00
`define WFP_IDX_CRC_HIGH    6'h02
`define WFP_IDX_MASK0       6'h04
`define WFP_IDX_MASK1       6'h06
`define WFP_IDX_MASK2       6'h08
`define WFP_IDX_MASK3       6'h0a
`define WFP_IDX_STATUS      6'h0c
`define WFP_IDX_BANK_SEL    6'h0e

// ****************************************************************
// Banks
// ****************************************************************
`define WFP_BANK_W          8
`define WFP_BANK_PATTERN2   8'h06
`define WFP_BANK_PATTERN3   8'h07
`define WFP_BANK_RSVD_FIRST 8'h08
`define WFP_BANK_RSVD_LAST  8'h0f
`define WFP_BANK_RESET      8'h00

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define WFP_REG_RESET       16'h0000
`define WFP_STAT_LAST       0
`define WFP_STAT_STICKY     1
`define WFP_CRC_POLY        32'hedb88320
`define WFP_CRC_INIT        32'hffffffff
`define WFP_MASK_BYTES      7'd64
`define WFP_CNT_W           7

`endif

// *** wfp_pkg.sv ***
package wfp_pkg;

   typedef enum logic [0:0] {
      WFP_IDLE     = 1'b0,
      WFP_IN_FRAME = 1'b1
   } wfp_frame_e;

   typedef logic [15:0] wfp_half_t;
   typedef logic [63:0] wfp_mask_t;

endpackage

// *** wfp_crc_matcher.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "wfp_map.svh"

module wfp_crc_matcher (
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_n,
   // Receive byte stream
   input  wire logic                  frameStart,
   input  wire logic                  byteValid,
   input  wire logic [7:0]            byteData,
   input  wire logic                  frameEnd,
   // Pattern
   input  wire wfp_pkg::wfp_mask_t    byteMask,
   input  wire logic [31:0]           expectedCrc,
   // Result
   output logic                       checkDone,
   output logic                       matchFound
);

   function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] d);
      logic [31:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[0] ^ d[i]) begin
            r = (r >> 1) ^ `WFP_CRC_POLY;
         end else begin
            r = r >> 1;
         end
      end
      return r;
   endfunction

   wfp_pkg::wfp_frame_e     state;
   logic [31:0]             crc;
   logic [`WFP_CNT_W-1:0]   byteCount;

   wire                     active     = frameStart | (state == wfp_pkg::WFP_IN_FRAME);
   wire [31:0]              crcBase    = frameStart ? `WFP_CRC_INIT : crc;
   wire [`WFP_CNT_W-1:0]    cntBase    = frameStart ? '0 : byteCount;
   wire                     inWindow   = cntBase < `WFP_MASK_BYTES;
   // Byte n of the frame is steered by mask bit n-1
   wire                     selected   = inWindow & byteMask[cntBase[5:0]];
   wire                     takeByte   = active & byteValid & selected;
   wire [31:0]              next_crc   = takeByte ? crcByte(crcBase, byteData) : crcBase;
   wire                     closing    = active & frameEnd;
   // An empty mask selects nothing and never matches
   wire                     maskInUse  = |byteMask;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state      <= wfp_pkg::WFP_IDLE;
         crc        <= `WFP_CRC_INIT;
         byteCount  <= '0;
         checkDone  <= 1'b0;
         matchFound <= 1'b0;
      end else begin
         checkDone  <= closing;
         matchFound <= closing & maskInUse & (~next_crc == expectedCrc);
         if (active) begin
            crc <= next_crc;
            if (byteValid && inWindow) begin
               byteCount <= cntBase + 7'd1;
            end else begin
               byteCount <= cntBase;
            end
         end
         case (state)
            wfp_pkg::WFP_IDLE: begin
               if (frameStart && !frameEnd) begin
                  state <= wfp_pkg::WFP_IN_FRAME;
               end
            end
            wfp_pkg::WFP_IN_FRAME: begin
               if (frameEnd && !frameStart) begin
                  state <= wfp_pkg::WFP_IDLE;
               end
            end
            default: begin
               state <= wfp_pkg::WFP_IDLE;
            end
         endcase
      end
   end

endmodule // wfp_crc_matcher

`default_nettype wire

// *** wfp_regs.sv ***
// Notes on behaviour
// - Check value is Ethernet CRC-32 over masked bytes
// - Expected CRC split into low and high halves
// - First mask bits 0..15 pick bytes 1..16
// - Second mask bits pick bytes 17..32
// - Third mask bits pick bytes 33..48
// - Fourth mask bits pick bytes 49..64
// - Pattern 2 in bank 6, pattern 3 bank 7
// - Banks 8..15 hold only bank select
//
// The APB slave port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "wfp_map.svh"

module wfp_regs (
   // Clock and reset
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   // APB slave
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`WFP_ADDR_W-1:0]  paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic [31:0]                  prdata,
   output logic                         pslverr,
   // Receive byte stream
   input  wire logic                    frameStart,
   input  wire logic                    byteValid,
   input  wire logic [7:0]              byteData,
   input  wire logic                    frameEnd,
   // Match results
   output logic [1:0]                   patternChecked,
   output logic [1:0]                   patternMatch,
   output logic [`WFP_BANK_W-1:0]       bankSelect
);

   // ****************************************************************
   // Byte-lane merge for 16-bit registers
   // ****************************************************************
   function automatic wfp_pkg::wfp_half_t mergeLanes(
      input wfp_pkg::wfp_half_t oldValue,
      input logic [15:0]        newValue,
      input logic [1:0]         lanes
   );
      wfp_pkg::wfp_half_t r;
      r = oldValue;
      if (lanes[0]) begin
         r[7:0] = newValue[7:0];
      end
      if (lanes[1]) begin
         r[15:8] = newValue[15:8];
      end
      return r;
   endfunction

   // ****************************************************************
   // Storage
   // ****************************************************************
   wfp_pkg::wfp_half_t   crcLow   [0:1];
   wfp_pkg::wfp_half_t   crcHigh  [0:1];
   wfp_pkg::wfp_half_t   mask0    [0:1];
   wfp_pkg::wfp_half_t   mask1    [0:1];
   wfp_pkg::wfp_half_t   mask2    [0:1];
   wfp_pkg::wfp_half_t   mask3    [0:1];
   logic [1:0]           lastMatch;
   logic [1:0]           stickyMatch;
   logic [1:0]           checkDone;
   logic [1:0]           matchFound;

   // ****************************************************************
   // Address decode
   // ****************************************************************
   wire [`WFP_IDX_W-1:0] regIndex   = paddr[`WFP_IDX_W+1:2];
   wire                  aligned    = paddr[1:0] == 2'b00;
   wire                  bankIsP2   = bankSelect == `WFP_BANK_PATTERN2;
   wire                  bankIsP3   = bankSelect == `WFP_BANK_PATTERN3;
   wire                  patBank    = bankIsP2 | bankIsP3;
   wire                  patSel     = bankIsP3;
   // Reserved banks decode only the bank select word
   wire                  bankRsvd   = (bankSelect >= `WFP_BANK_RSVD_FIRST) &&
                                      (bankSelect <= `WFP_BANK_RSVD_LAST);
   wire                  hitBankSel = aligned & (regIndex == `WFP_IDX_BANK_SEL);
   wire                  hitCrcLow  = aligned & patBank & (regIndex == `WFP_IDX_CRC_LOW);
   wire                  hitCrcHigh = aligned & patBank & (regIndex == `WFP_IDX_CRC_HIGH);
   wire                  hitMask0   = aligned & patBank & (regIndex == `WFP_IDX_MASK0);
   wire                  hitMask1   = aligned & patBank & (regIndex == `WFP_IDX_MASK1);
   wire                  hitMask2   = aligned & patBank & (regIndex == `WFP_IDX_MASK2);
   wire                  hitMask3   = aligned & patBank & (regIndex == `WFP_IDX_MASK3);
   wire                  hitStatus  = aligned & patBank & (regIndex == `WFP_IDX_STATUS);
   wire                  hitPattern = hitCrcLow | hitCrcHigh | hitMask0 | hitMask1 |
                                      hitMask2 | hitMask3 | hitStatus;
   wire                  mapped     = hitBankSel | (hitPattern & ~bankRsvd);

   // ****************************************************************
   // APB phases
   // ****************************************************************
   wire                  setupPhase = psel & ~penable;
   wire                  accessDone = psel & penable;
   wire                  writeDone  = accessDone & pwrite & mapped;
   wire [1:0]            lanes      = pstrb[1:0];

   // No wait states: read data is captured in the setup cycle
   assign pready = accessDone;

   // ****************************************************************
   // Read selection
   // ****************************************************************
   wire [15:0]           statusWord = {14'h0000,
                                       stickyMatch[patSel],
                                       lastMatch[patSel]};
   wire [15:0]           bankWord   = {{(16-`WFP_BANK_W){1'b0}}, bankSelect};
   wire [15:0]           readHalf   = hitBankSel ? bankWord :
                                      hitCrcLow  ? crcLow[patSel] :
                                      hitCrcHigh ? crcHigh[patSel] :
                                      hitMask0   ? mask0[patSel] :
                                      hitMask1   ? mask1[patSel] :
                                      hitMask2   ? mask2[patSel] :
                                      hitMask3   ? mask3[patSel] :
                                      hitStatus  ? statusWord :
                                      16'h0000;
   wire [31:0]           readWord   = mapped ? {16'h0000, readHalf} : 32'h0000_0000;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setupPhase) begin
         prdata  <= pwrite ? 32'h0000_0000 : readWord;
         pslverr <= ~mapped;
      end
   end

   // ****************************************************************
   // Bank select
   // ****************************************************************
   wire                  wrBankSel  = writeDone & hitBankSel & lanes[0];

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bankSelect <= `WFP_BANK_RESET;
      end else if (wrBankSel) begin
         bankSelect <= pwdata[`WFP_BANK_W-1:0];
      end
   end

   // ****************************************************************
   // Per-pattern registers and checkers
   // ****************************************************************
   genvar p;
   generate
      for (p = 0; p < 2; p++) begin : gPattern
         wire                 mine      = writeDone & (patSel == 1'(p));
         wire                 wrCrcLow  = mine & hitCrcLow;
         wire                 wrCrcHigh = mine & hitCrcHigh;
         wire                 wrMask0   = mine & hitMask0;
         wire                 wrMask1   = mine & hitMask1;
         wire                 wrMask2   = mine & hitMask2;
         wire                 wrMask3   = mine & hitMask3;
         // Write one to bit 1 clears the sticky flag
         wire                 clrSticky = mine & hitStatus & lanes[0] &
                                          pwdata[`WFP_STAT_STICKY];
         // Mask 0 owns bytes 1..16, mask 3 bytes 49..64
         wire wfp_pkg::wfp_mask_t byteMask = {mask3[p], mask2[p],
                                              mask1[p], mask0[p]};
         wire [31:0]          expected  = {crcHigh[p], crcLow[p]};

         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               crcLow[p]  <= `WFP_REG_RESET;
               crcHigh[p] <= `WFP_REG_RESET;
            end else begin
               if (wrCrcLow) begin
                  crcLow[p] <= mergeLanes(crcLow[p], pwdata[15:0], lanes);
               end
               if (wrCrcHigh) begin
                  crcHigh[p] <= mergeLanes(crcHigh[p], pwdata[15:0], lanes);
               end
            end
         end

         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               mask0[p] <= `WFP_REG_RESET;
               mask1[p] <= `WFP_REG_RESET;
               mask2[p] <= `WFP_REG_RESET;
               mask3[p] <= `WFP_REG_RESET;
            end else begin
               if (wrMask0) begin
                  mask0[p] <= mergeLanes(mask0[p], pwdata[15:0], lanes);
               end
               if (wrMask1) begin
                  mask1[p] <= mergeLanes(mask1[p], pwdata[15:0], lanes);
               end
               if (wrMask2) begin
                  mask2[p] <= mergeLanes(mask2[p], pwdata[15:0], lanes);
               end
               if (wrMask3) begin
                  mask3[p] <= mergeLanes(mask3[p], pwdata[15:0], lanes);
               end
            end
         end

         // A match in the clearing cycle keeps the sticky flag set
         always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
               lastMatch[p]   <= 1'b0;
               stickyMatch[p] <= 1'b0;
            end else begin
               if (checkDone[p]) begin
                  lastMatch[p] <= matchFound[p];
               end
               stickyMatch[p] <= matchFound[p] | (stickyMatch[p] & ~clrSticky);
            end
         end

         wfp_crc_matcher uMatcher (
            .clk_sys     (clk_sys),
            .rst_n       (rst_n),
            .frameStart  (frameStart),
            .byteValid   (byteValid),
            .byteData    (byteData),
            .frameEnd    (frameEnd),
            .byteMask    (byteMask),
            .expectedCrc (expected),
            .checkDone   (checkDone[p]),
            .matchFound  (matchFound[p])
         );
      end
   endgenerate

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign patternChecked = checkDone;
   assign patternMatch   = matchFound;

endmodule // wfp_regs

`default_nettype wire

// *** wfp_regs_assertions.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "wfp_map.svh"

module wfp_regs_assertions (
   // Clock and reset
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   // APB
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [`WFP_ADDR_W-1:0] paddr,
   input  wire logic [31:0]            pwdata,
   input  wire logic [3:0]             pstrb,
   input  wire logic [31:0]            prdata,
   input  wire logic                   pslverr,
   // Frame results
   input  wire logic                   frameEnd,
   input  wire logic [1:0]             patternChecked,
   input  wire logic [1:0]             patternMatch,
   input  wire logic [`WFP_BANK_W-1:0] bankSelect
);
   // ****************************************************************
   // Decodes
   // ****************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire setupCycle = psel && !penable;
   wire bselAddr   = paddr == 8'h38;
   wire rsvdBank   = bankSelect >= 8'h08 && bankSelect <= 8'h0f;
   wire patBank    = bankSelect == 8'h06 || bankSelect == 8'h07;
   wire patAddr    = paddr[2:0] == 3'h0 && paddr[7:2] <= 6'h0a;
   wire bselWrite  = psel && penable && pwrite && bselAddr;

   // ****************************************************************
   // Properties
   // ****************************************************************
   check_after_end_a: assert property (patternChecked != 2'b00 |->
      $past(frameEnd) && patternChecked == 2'b11) else $error("check pulse without frame end");
   match_needs_check_a: assert property ((patternMatch & ~patternChecked) == 2'b00)
      else $error("match outside a check pulse");
   bank_write_a: assert property (bselWrite && pstrb[0] |=>
      {24'h0, bankSelect} == ($past(pwdata) & 32'hff)) else $error("bank select not written");
   bank_hold_a: assert property (!bselWrite |=> $stable(bankSelect))
      else $error("bank select changed without write");
   rsvd_refuse_a: assert property (setupCycle && rsvdBank && !bselAddr |=>
      pslverr && prdata == 32'h0) else $error("reserved bank access not refused");
   bsel_read_a: assert property (setupCycle && bselAddr && !pwrite |=>
      !pslverr && prdata == {24'h0, $past(bankSelect)}) else $error("bank select read wrong");
   pattern_map_a: assert property (setupCycle && patBank && patAddr |=>
      !pslverr && prdata[31:16] == 16'h0) else $error("pattern register not mapped");
   unaligned_a: assert property (setupCycle && paddr[1:0] != 2'b00 |=> pslverr)
      else $error("unaligned access not refused");
endmodule // wfp_regs_assertions

bind wfp_regs wfp_regs_assertions chk (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .prdata, .pslverr, .frameEnd, .patternChecked, .patternMatch, .bankSelect);
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "wfp_map.svh"

module tb;
   // ****************************************************************
   // Signals and design
   // ****************************************************************
   logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, rdErr;
   logic        frameStart, byteValid, frameEnd;
   logic [7:0]  paddr, byteData, bankSelect;
   logic [31:0] pwdata, prdata, rdData, c2, c3;
   logic [3:0]  pstrb;
   logic [1:0]  patternChecked, patternMatch;
   logic [63:0] m2, m3;
   int          n_fail = 0;
   int          n_checks = 0;
   localparam logic [7:0] BSEL = 8'h38;
   localparam logic [7:0] A [6] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28};

   wfp_regs dut (.clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
      .prdata, .pslverr, .frameStart, .byteValid, .byteData, .frameEnd, .patternChecked,
      .patternMatch, .bankSelect);

   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_sys);
         k++;
         if (k > 20) begin
            n_fail++;
            end_sim;
         end
      end while (pready !== 1'b1);
      rdData = prdata;
      rdErr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
      apb(1'b0, a, 32'h0);
      chk("read data", exp, rdData);
      chk("slave error", {31'h0, err}, {31'h0, rdErr});
   endtask

   task automatic bank(input logic [7:0] b);
      apb(1'b1, BSEL, {24'h0, b});
   endtask

   task automatic prog(input logic [7:0] b, input logic [63:0] m, input logic [31:0] c);
      bank(b);
      apb(1'b1, A[0], {16'h0, c[15:0]});
      apb(1'b1, A[1], {16'h0, c[31:16]});
      for (int k = 0; k < 4; k++) apb(1'b1, A[2+k], {16'h0, m[16*k +: 16]});
   endtask

   task automatic readPat(input logic [7:0] b, input logic [63:0] m, input logic [31:0] c);
      bank(b);
      rd(A[0], {16'h0, c[15:0]}, 1'b0);
      rd(A[1], {16'h0, c[31:16]}, 1'b0);
      for (int k = 0; k < 4; k++) rd(A[2+k], {16'h0, m[16*k +: 16]}, 1'b0);
   endtask

   function automatic logic [7:0] fb(input int i);
      return 8'(i * 37 + 5);
   endfunction

   // Reference check value: only selected bytes, only the first 64
   function automatic logic [31:0] crcOf(input logic [63:0] m, input int n);
      logic [31:0] c;
      c = `WFP_CRC_INIT;
      for (int i = 1; i <= n && i <= 64; i++) if (m[i-1]) begin
         c ^= {24'h0, fb(i)};
         for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ `WFP_CRC_POLY : c >> 1;
      end
      return ~c;
   endfunction

   task automatic frame(input int n, input logic [1:0] expMatch);
      for (int i = 1; i <= n; i++) begin
         @(posedge clk_sys);
         frameStart <= (i == 1); byteValid <= 1'b1; byteData <= fb(i); frameEnd <= (i == n);
      end
      @(posedge clk_sys);
      frameStart <= 1'b0; byteValid <= 1'b0; frameEnd <= 1'b0;
      #1;
      chk("checked", 32'h3, {30'h0, patternChecked});
      chk("match", {30'h0, expMatch}, {30'h0, patternMatch});
   endtask

   // ****************************************************************
   // Tests
   // ****************************************************************
   initial begin
      rst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0;
      pwdata = 32'h0; pstrb = 4'hf; frameStart = 1'b0; byteValid = 1'b0;
      frameEnd = 1'b0; byteData = 8'h0;
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      readPat(8'h06, 64'h0, 32'h0);
      readPat(8'h07, 64'h0, 32'h0);
      rd(BSEL, 32'h7, 1'b0);
      $display("test reset values done");
      // Boundary bits: bytes 1, 16, 17, 33, 48, 64
      m2 = 64'h8000_0000_0000_0001;
      m3 = 64'h0000_8001_0001_8000;
      c2 = crcOf(m2, 70);
      c3 = crcOf(m3, 70);
      prog(8'h06, m2, c2);
      prog(8'h07, m3, ~c3);
      readPat(8'h06, m2, c2);
      readPat(8'h07, m3, ~c3);
      $display("test bank layout done");
      frame(70, 2'b01);
      prog(8'h07, m3, c3);
      frame(48, 2'b10);
      frame(70, 2'b11);
      bank(8'h06);
      rd(8'h30, 32'h3, 1'b0);
      apb(1'b1, 8'h30, 32'h2);
      rd(8'h30, 32'h1, 1'b0);
      $display("test pattern match done");
      bank(8'h09);
      rd(A[0], 32'h0, 1'b1);
      apb(1'b1, A[0], 32'hffff);
      rd(BSEL, 32'h9, 1'b0);
      bank(8'h0f);
      rd(A[5], 32'h0, 1'b1);
      bank(8'h06);
      rd(A[0], {16'h0, c2[15:0]}, 1'b0);
      chk("bank port", 32'h6, {24'h0, bankSelect});
      pstrb <= 4'h2;
      apb(1'b1, A[0], 32'h0000_a5a5);
      pstrb <= 4'hf;
      rd(A[0], {16'h0, 8'ha5, c2[7:0]}, 1'b0);
      rd(8'h01, 32'h0, 1'b1);
      $display("test reserved banks done");
      end_sim;
   end
endmodule // tb
`default_nettype wire
